/* hdl/rtw_params.svh */
// constants shared by the render target write message ends
`ifndef RTW_PARAMS_SVH
`define RTW_PARAMS_SVH
// message shape
`define RTW_PIX           32
`define RTW_DW_BITS       32
`define RTW_HDR_DW        6
`define RTW_DW_X          0
`define RTW_DW_Y          1
`define RTW_DW_MASK       2
`define RTW_DW_TAG        5
`define RTW_TAG_W         8
`define RTW_BTI_W         8
`define RTW_BTI_STATELESS 8'hff
`define RTW_ALL_LIT       32'hffffffff
`define RTW_Y_MBZ_MSB     1
`define RTW_X_MBZ_MSB     2
`define RTW_COORD_W       14
`define RTW_ARRAY_W       11
`define RTW_KIND_W        3
// register offsets of the sender end, byte addresses
`define RTW_A_X           8'h00
`define RTW_A_Y           8'h04
`define RTW_A_MASK        8'h08
`define RTW_A_TAG         8'h0c
`define RTW_A_ARRAY       8'h10
`define RTW_A_EXEC        8'h14
`define RTW_A_CTRL        8'h18
`define RTW_A_SURF        8'h1c
`define RTW_A_STAT        8'h20
// control register fields
`define RTW_C_HDR         0
`define RTW_C_EOT         1
`define RTW_C_RD          2
`define RTW_C_DLO         3
`define RTW_C_DHI         4
`define RTW_C_SLOT        5
`define RTW_C_BTI_LSB     8
// surface register fields
`define RTW_S_FIELD       0
`define RTW_S_ROT         1
`define RTW_S_NONCONTIG   2
`define RTW_S_FMT_RT      3
`define RTW_S_FMT_BLEND   4
`define RTW_S_BLEND       5
`define RTW_S_KIND_LSB    8
// refusal causes, status bits
`define RTW_E_W           9
`define RTW_E_BTI         0
`define RTW_E_KERN        1
`define RTW_E_ROT         2
`define RTW_E_FIELD       3
`define RTW_E_ORDER       4
`define RTW_E_FMT         5
`define RTW_E_ALIGN       6
`define RTW_E_COORD       7
`define RTW_E_BUSY        8
`define RTW_ST_ERR_LSB    8
`endif

/* hdl/rtw_pkg.sv */
// types shared by the render target write message ends
package rtw_pkg;
  `include "rtw_params.svh"

  typedef logic [`RTW_DW_BITS-1:0]  rtw_dw_t;
  typedef rtw_dw_t [`RTW_HDR_DW-1:0] rtw_hdr_t;

  typedef enum logic [`RTW_KIND_W-1:0] {
    one_dim_surface_kind           = 3'h0,
    two_dim_surface_kind           = 3'h1,
    three_dim_surface_kind         = 3'h2,
    cube_surface_kind              = 3'h3,
    linear_buffer_surface_kind     = 3'h4,
    structured_buffer_surface_kind = 3'h5
  } rtw_surf_kind_t;

  typedef enum logic [1:0] {
    RTW_T_IDLE = 2'h1,
    RTW_T_WR   = 2'h2
  } rtw_tstate_t;

  typedef enum logic [1:0] {
    RTW_H_IDLE = 2'h1,
    RTW_H_SEND = 2'h2
  } rtw_hstate_t;
endpackage : rtw_pkg

/* hdl/rtw_if.sv */
// message link between the pixel shader thread and the render target writer
`timescale 1ns/1ns
`include "rtw_params.svh"
interface rtw_if;
  import rtw_pkg::*;
  logic                        valid;
  logic                        ready;
  logic                        hdr_en;
  logic                        thread_done_flag;
  logic                        rd;
  logic                        dual_source_low_half_msg;
  logic                        dual_source_high_half_msg;
  logic                        slot_hi;
  logic [`RTW_BTI_W-1:0]       bti;
  logic [`RTW_ARRAY_W-1:0]     array_idx;
  logic [`RTW_PIX-1:0]         exec_mask;
  rtw_hdr_t                    hdr;

  modport sender (
    output valid, hdr_en, thread_done_flag, rd, dual_source_low_half_msg,
           dual_source_high_half_msg, slot_hi, bti, array_idx, exec_mask, hdr,
    input  ready
  );
  modport target (
    input  valid, hdr_en, thread_done_flag, rd, dual_source_low_half_msg,
           dual_source_high_half_msg, slot_hi, bti, array_idx, exec_mask, hdr,
    output ready
  );
endinterface : rtw_if

/* hdl/rtw_target.sv */
// render target write message handler, device end
`timescale 1ns/1ns
`include "rtw_params.svh"
module rtw_target #(
  parameter int COORD_W = `RTW_COORD_W,
  parameter int ARRAY_W = `RTW_ARRAY_W
) (
  rtw_if.target                     link,
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire rtw_pkg::rtw_surf_kind_t SURF_KIND,
  input  wire logic [COORD_W-1:0]   SURF_WIDTH,
  input  wire logic [COORD_W-1:0]   SURF_HEIGHT,
  input  wire logic [ARRAY_W-1:0]   SURF_DEPTH,
  input  wire logic                 BLEND_EN,
  input  wire logic                 DEPTH_EN,
  input  wire logic                 MEM_READY,
  output logic                      MEM_VALID,
  output logic                      MEM_READ,
  output logic [`RTW_DW_BITS-1:0]   MEM_X,
  output logic [`RTW_DW_BITS-1:0]   MEM_Y,
  output logic [ARRAY_W-1:0]        MEM_ARRAY,
  output logic [`RTW_PIX-1:0]       MEM_MASK,
  output logic                      DS_START,
  output logic                      DEST_RD_START,
  output logic                      CC_START,
  output logic                      SB_CLR,
  output logic [`RTW_TAG_W-1:0]     SB_TAG,
  output logic                      MSG_DROP,
  output logic                      OOB_SEEN,
  output logic                      ARRAY_CLAMP
);
  import rtw_pkg::*;

  // the link fixes the slice width, so only that value can be served
  if (COORD_W < 1 || COORD_W >= `RTW_DW_BITS || ARRAY_W != `RTW_ARRAY_W) begin : g_bad_param
    $error("rtw_target: unsupported COORD_W or ARRAY_W");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rtw_tstate_t               state;
    logic                      ready;
    logic                      mem_valid;
    logic                      mem_read;
    logic [`RTW_DW_BITS-1:0]   mem_x;
    logic [`RTW_DW_BITS-1:0]   mem_y;
    logic [ARRAY_W-1:0]        mem_array;
    logic [`RTW_PIX-1:0]       mem_mask;
    logic                      ds_start;
    logic                      dest_rd_start;
    logic                      cc_start;
    logic                      done_flag;
    logic                      sb_clr;
    logic [`RTW_TAG_W-1:0]     sb_tag;
    logic                      drop;
    logic                      oob;
    logic                      clamp;
  } rtw_tgt_state_t;

  rtw_tgt_state_t s_reg;
  rtw_tgt_state_t s_next;

  // ----------------------------------------------------------------
  // message decode
  // ----------------------------------------------------------------
  logic                      x_only;
  logic                      take;
  logic signed [`RTW_DW_BITS-1:0] x_org;
  logic signed [`RTW_DW_BITS-1:0] y_org;
  logic signed [`RTW_DW_BITS-1:0] w_lim;
  logic signed [`RTW_DW_BITS-1:0] h_lim;
  logic [`RTW_PIX-1:0]       lit;
  logic [`RTW_PIX-1:0]       inb;
  logic                      arr_oor;
  logic [ARRAY_W-1:0]        arr_eff;

  assign take   = link.valid && s_reg.ready;
  // linear and 1D surfaces see one row only; y forced to the origin
  assign x_only = (SURF_KIND == one_dim_surface_kind) ||
                  (SURF_KIND == linear_buffer_surface_kind);
  assign x_org  = signed'(link.hdr[`RTW_DW_X]);
  assign y_org  = x_only ? '0 : signed'(link.hdr[`RTW_DW_Y]);
  assign w_lim  = signed'(32'(SURF_WIDTH));
  assign h_lim  = x_only ? signed'(32'(1)) : signed'(32'(SURF_HEIGHT));

  // no header: the sideband channel enables stand in for the lit mask
  assign lit = link.hdr_en ? link.hdr[`RTW_DW_MASK] : link.exec_mask;

  // array slice is a coordinate; buffers ignore it, bad slices fall to 0
  assign arr_oor = (SURF_KIND != linear_buffer_surface_kind) &&
                   (link.array_idx >= SURF_DEPTH);
  assign arr_eff = (SURF_KIND == linear_buffer_surface_kind || arr_oor) ?
                   '0 : link.array_idx;

  // ----------------------------------------------------------------
  // per-pixel bounds; the block is 8 wide by 4 rows of pixels, in 2x2 subspans
  // ----------------------------------------------------------------
  for (genvar b = 0; b < `RTW_PIX; b++) begin : g_pix
    localparam logic signed [`RTW_DW_BITS-1:0] COL =
      32'((b % 2) + 2 * ((b / 4) % 2) + 4 * ((b / 16) % 2));
    localparam logic signed [`RTW_DW_BITS-1:0] ROW =
      32'(((b / 2) % 2) + 2 * ((b / 8) % 2));
    logic signed [`RTW_DW_BITS-1:0] px;
    logic signed [`RTW_DW_BITS-1:0] py;
    assign px     = x_org + COL;
    assign py     = y_org + ROW;
    // negative coordinates are outside as well as beyond the far edge
    assign inb[b] = !px[`RTW_DW_BITS-1] && (px < w_lim) &&
                    !py[`RTW_DW_BITS-1] && (py < h_lim);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next               = s_reg;
    s_next.ds_start      = 1'b0;
    s_next.dest_rd_start = 1'b0;
    s_next.cc_start      = 1'b0;
    s_next.sb_clr        = 1'b0;
    s_next.drop          = 1'b0;
    s_next.oob           = 1'b0;
    s_next.clamp         = 1'b0;
    unique case (s_reg.state)
      RTW_T_IDLE: begin
        if (take) begin
          // dword 3, dword 4 and the binding index are never looked at
          s_next.sb_tag = link.hdr[`RTW_DW_TAG][`RTW_TAG_W-1:0];
          if (SURF_KIND == structured_buffer_surface_kind) begin
            // unsupported surface: swallow the message, still free the thread
            s_next.drop   = 1'b1;
            s_next.sb_clr = link.thread_done_flag;
          end else begin
            s_next.state     = RTW_T_WR;
            s_next.ready     = 1'b0;
            s_next.mem_valid = 1'b1;
            s_next.mem_read  = link.rd;
            s_next.mem_x     = x_org;
            s_next.mem_y     = y_org;
            s_next.mem_array = arr_eff;
            s_next.clamp     = arr_oor;
            s_next.done_flag = link.thread_done_flag;
            if (link.rd) begin
              s_next.mem_mask = `RTW_ALL_LIT;
            end else begin
              s_next.mem_mask = lit & inb;
              s_next.oob      = |(lit & ~inb);
              s_next.cc_start      = 1'b1;
              s_next.ds_start      = DEPTH_EN;
              s_next.dest_rd_start = BLEND_EN;
            end
          end
        end
      end
      RTW_T_WR: begin
        if (MEM_READY) begin
          s_next.state     = RTW_T_IDLE;
          s_next.ready     = 1'b1;
          s_next.mem_valid = 1'b0;
          // scoreboard freed only after the last write has been taken
          s_next.sb_clr    = s_reg.done_flag;
        end
      end
      default: begin
        s_next.state     = RTW_T_IDLE;
        s_next.ready     = 1'b1;
        s_next.mem_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg       <= '0;
      s_reg.state <= RTW_T_IDLE;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state flops
  // ----------------------------------------------------------------
  assign link.ready    = s_reg.ready;
  assign MEM_VALID     = s_reg.mem_valid;
  assign MEM_READ      = s_reg.mem_read;
  assign MEM_X         = s_reg.mem_x;
  assign MEM_Y         = s_reg.mem_y;
  assign MEM_ARRAY     = s_reg.mem_array;
  assign MEM_MASK      = s_reg.mem_mask;
  assign DS_START      = s_reg.ds_start;
  assign DEST_RD_START = s_reg.dest_rd_start;
  assign CC_START      = s_reg.cc_start;
  assign SB_CLR        = s_reg.sb_clr;
  assign SB_TAG        = s_reg.sb_tag;
  assign MSG_DROP      = s_reg.drop;
  assign OOB_SEEN      = s_reg.oob;
  assign ARRAY_CLAMP   = s_reg.clamp;
endmodule : rtw_target

/* hdl/rtw_sender.sv */
// pixel shader thread end: APB-programmed message sender with checks
`timescale 1ns/1ns
`include "rtw_params.svh"
module rtw_sender #(
  parameter int ADDR_W = 8
) (
  rtw_if.sender                     link,
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR
);
  import rtw_pkg::*;

  if (ADDR_W != 8) begin : g_bad_param
    $error("rtw_sender: ADDR_W must be 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rtw_hstate_t               state;
    rtw_dw_t                   x;
    rtw_dw_t                   y;
    rtw_dw_t                   mask;
    rtw_dw_t                   tag;
    logic [`RTW_ARRAY_W-1:0]   array_idx;
    rtw_dw_t                   exec;
    rtw_dw_t                   surf;
    logic [`RTW_BTI_W-1:0]     bti;
    logic [5:0]                ctl;
    logic [1:0]                lo_seen;
    logic [`RTW_E_W-1:0]       err;
    logic                      pready;
    logic                      pslverr;
    rtw_dw_t                   prdata;
  } rtw_snd_state_t;

  rtw_snd_state_t s_reg;
  rtw_snd_state_t s_next;

  // ----------------------------------------------------------------
  // launch checks against the pending control word
  // ----------------------------------------------------------------
  logic                      dlo;
  logic                      dhi;
  logic                      slot;
  logic                      x_only;
  logic [`RTW_KIND_W-1:0]    kind;
  logic [`RTW_E_W-1:0]       cause;
  logic                      hit;
  rtw_dw_t                   rd_val;

  assign dlo    = PWDATA[`RTW_C_DLO];
  assign dhi    = PWDATA[`RTW_C_DHI];
  assign slot   = PWDATA[`RTW_C_SLOT];
  assign kind   = s_reg.surf[`RTW_S_KIND_LSB +: `RTW_KIND_W];
  assign x_only = kind == one_dim_surface_kind || kind == linear_buffer_surface_kind;

  always_comb begin
    cause = '0;
    cause[`RTW_E_BTI]   = PWDATA[`RTW_C_BTI_LSB +: `RTW_BTI_W] == `RTW_BTI_STATELESS;
    cause[`RTW_E_KERN]  = !s_reg.surf[`RTW_S_NONCONTIG];
    cause[`RTW_E_ROT]   = (dlo || dhi) && s_reg.surf[`RTW_S_ROT];
    cause[`RTW_E_FIELD] = s_reg.surf[`RTW_S_FIELD];
    cause[`RTW_E_ORDER] = dhi && !s_reg.lo_seen[slot];
    cause[`RTW_E_FMT]   = !s_reg.surf[`RTW_S_FMT_RT] ||
                          (s_reg.surf[`RTW_S_BLEND] && !s_reg.surf[`RTW_S_FMT_BLEND]);
    cause[`RTW_E_ALIGN] = |s_reg.y[`RTW_Y_MBZ_MSB:0] ||
                          |s_reg.x[`RTW_X_MBZ_MSB:0];
    cause[`RTW_E_COORD] = (x_only && |s_reg.y) ||
                          (kind == linear_buffer_surface_kind && |s_reg.array_idx);
    cause[`RTW_E_BUSY]  = s_reg.state != RTW_H_IDLE;
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (PADDR)
      `RTW_A_X:     rd_val = s_reg.x;
      `RTW_A_Y:     rd_val = s_reg.y;
      `RTW_A_MASK:  rd_val = s_reg.mask;
      `RTW_A_TAG:   rd_val = s_reg.tag;
      `RTW_A_ARRAY: rd_val = 32'(s_reg.array_idx);
      `RTW_A_EXEC:  rd_val = s_reg.exec;
      `RTW_A_CTRL:  rd_val = 32'({s_reg.bti, 2'h0, s_reg.ctl});
      `RTW_A_SURF:  rd_val = s_reg.surf;
      `RTW_A_STAT:  rd_val = 32'({s_reg.err, 7'h0, s_reg.state == RTW_H_SEND});
      default:      hit    = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state; one wait state so read data comes from a flop
  // ----------------------------------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    if (PSEL && PENABLE && !s_reg.pready) begin
      s_next.pready  = 1'b1;
      s_next.prdata  = PWRITE ? '0 : rd_val;
      s_next.pslverr = !hit;
    end
    unique case (s_reg.state)
      RTW_H_IDLE: ;
      RTW_H_SEND: begin
        if (link.ready) begin
          s_next.state = RTW_H_IDLE;
        end
      end
      default: s_next.state = RTW_H_IDLE;
    endcase
    // writes land at the completing edge only
    if (PSEL && PENABLE && s_reg.pready && PWRITE) begin
      unique case (PADDR)
        `RTW_A_X:     s_next.x         = PWDATA;
        `RTW_A_Y:     s_next.y         = PWDATA;
        `RTW_A_MASK:  s_next.mask      = PWDATA;
        `RTW_A_TAG:   s_next.tag       = PWDATA;
        `RTW_A_ARRAY: s_next.array_idx = PWDATA[`RTW_ARRAY_W-1:0];
        `RTW_A_EXEC:  s_next.exec      = PWDATA;
        `RTW_A_SURF:  s_next.surf      = PWDATA;
        `RTW_A_CTRL: begin
          s_next.err = cause;
          if (cause == '0) begin
            s_next.bti   = PWDATA[`RTW_C_BTI_LSB +: `RTW_BTI_W];
            s_next.ctl   = PWDATA[5:0];
            s_next.state = RTW_H_SEND;
            // a low half in the same launch wins over the clear
            if (dhi) begin
              s_next.lo_seen[slot] = 1'b0;
            end
            if (dlo) begin
              s_next.lo_seen[slot] = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg       <= '0;
      s_reg.state <= RTW_H_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA                         = s_reg.prdata;
  assign PREADY                         = s_reg.pready;
  assign PSLVERR                        = s_reg.pslverr;
  assign link.valid                     = s_reg.state == RTW_H_SEND;
  assign link.hdr_en                    = s_reg.ctl[`RTW_C_HDR];
  assign link.thread_done_flag          = s_reg.ctl[`RTW_C_EOT];
  assign link.rd                        = s_reg.ctl[`RTW_C_RD];
  assign link.dual_source_low_half_msg  = s_reg.ctl[`RTW_C_DLO];
  assign link.dual_source_high_half_msg = s_reg.ctl[`RTW_C_DHI];
  assign link.slot_hi                   = s_reg.ctl[`RTW_C_SLOT];
  assign link.bti                       = s_reg.bti;
  assign link.array_idx                 = s_reg.array_idx;
  assign link.exec_mask                 = s_reg.exec;
  // reserved dwords travel as zero; the target ignores them anyway
  assign link.hdr = {s_reg.tag, 32'h0, 32'h0, s_reg.mask, s_reg.y, s_reg.x};
endmodule : rtw_sender

/* verif/rtw_props.sv */
// concurrent checks on the message link between sender and render target writer
`timescale 1ns/1ns
module rtw_props (
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              valid,
  input wire logic              ready,
  input wire logic              thread_done_flag,
  input wire logic              dual_source_low_half_msg,
  input wire logic              dual_source_high_half_msg,
  input wire logic              slot_hi,
  input wire logic [7:0]        bti,
  input wire rtw_pkg::rtw_hdr_t hdr
);
  import rtw_pkg::*;
  // ----------------------------------------------------------------
  // low-half history per slot group, cleared only by reset: only a weaker check
  // ----------------------------------------------------------------
  logic [1:0] lo_seen_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) lo_seen_reg <= 2'h0;
    else if (valid && ready && dual_source_low_half_msg) lo_seen_reg[slot_hi] <= 1'b1;
  end
  AST_NO_STATELESS: assert property (valid |-> bti != 8'hff)
    else $error("stateless binding index offered");
  AST_X_ALIGN: assert property (valid |-> hdr[0][2:0] == 3'h0)
    else $error("x offset not eight-pixel aligned");
  AST_Y_ALIGN: assert property (valid |-> hdr[1][1:0] == 2'h0)
    else $error("y offset not four-row aligned");
  AST_HOLD: assert property (valid && !ready |=> valid && $stable(hdr) && $stable(bti))
    else $error("message changed before it was taken");
  AST_TAKE_ONCE: assert property (valid && ready |=> !valid)
    else $error("message offered again after take");
  AST_READY_BACK: assert property (!ready |-> ##[1:40] ready)
    else $error("writer stayed busy too long");
  AST_DUAL_ORDER: assert property (valid && dual_source_high_half_msg |-> lo_seen_reg[slot_hi])
    else $error("high half before low half");
  AST_RSVD_DW: assert property (valid |-> hdr[3] == 32'h0 && hdr[4] == 32'h0)
    else $error("ignored header dwords not zero");
  cover property (valid && ready && thread_done_flag);
  cover property (valid && ready && dual_source_high_half_msg);
  cover property (!ready ##1 ready);
endmodule : rtw_props

/* verif/tb_top.sv */
// self-checking bench: APB-driven sender facing the render target writer
`timescale 1ns/1ns
module tb_top;
  import rtw_pkg::*;
  // ----------------------------------------------------------------
  // signals, instances
  // ----------------------------------------------------------------
  logic           CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, e, mr;
  logic           MEM_READY = 0, BLEND_EN = 1, DEPTH_EN = 1, PREADY, PSLVERR, MEM_VALID;
  logic           MEM_READ, DS_START, DEST_RD_START, CC_START, SB_CLR, MSG_DROP, OOB_SEEN;
  logic           ARRAY_CLAMP, clr = 0;
  logic [7:0]     PADDR = 8'h00, SB_TAG;
  logic [31:0]    PWDATA = 32'h0, PRDATA, MEM_X, MEM_Y, MEM_MASK, r, mx, my, mm, st;
  logic [13:0]    SURF_WIDTH = 14'h3c, SURF_HEIGHT = 14'h8;
  logic [10:0]    SURF_DEPTH = 11'h4, MEM_ARRAY, ma;
  logic [6:0]     seen = 7'h0;
  rtw_surf_kind_t SURF_KIND = two_dim_surface_kind;
  int             mismatches = 0, n_checks = 0;
  logic [31:0]    sv[8] = '{32'h10c, 32'h108, 32'h10e, 32'h10d, 32'h10c, 32'h104, 32'h10c, 32'h10c};
  logic [31:0]    cv[8] = '{32'hff01, 32'h101, 32'h109, 32'h101, 32'h131, 32'h101, 32'h101, 32'h101};
  int             xs[8] = '{0, 0, 0, 0, 0, 0, 4, 0};
  int             ys[8] = '{0, 0, 0, 0, 0, 0, 0, 2};
  rtw_if u_rtw_if ();
  rtw_sender u_rtw_sender (.link(u_rtw_if), .CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  rtw_target u_rtw_target (.link(u_rtw_if), .CLK, .RESETN, .SURF_KIND, .SURF_WIDTH,
    .SURF_HEIGHT, .SURF_DEPTH, .BLEND_EN, .DEPTH_EN, .MEM_READY, .MEM_VALID, .MEM_READ, .MEM_X,
    .MEM_Y, .MEM_ARRAY, .MEM_MASK, .DS_START, .DEST_RD_START, .CC_START, .SB_CLR, .SB_TAG,
    .MSG_DROP, .OOB_SEEN, .ARRAY_CLAMP);
  rtw_props u_rtw_props (.CLK, .RESETN, .valid(u_rtw_if.valid), .ready(u_rtw_if.ready),
    .thread_done_flag(u_rtw_if.thread_done_flag), .bti(u_rtw_if.bti), .hdr(u_rtw_if.hdr),
    .dual_source_low_half_msg(u_rtw_if.dual_source_low_half_msg),
    .dual_source_high_half_msg(u_rtw_if.dual_source_high_half_msg), .slot_hi(u_rtw_if.slot_hi));
  always #10 CLK = ~CLK;
  // pulses gathered on the falling edge, clear of any launching edge
  always @(negedge CLK) seen <= clr ? 7'h0 : seen | {ARRAY_CLAMP, OOB_SEEN, MSG_DROP, SB_CLR,
                                                     CC_START, DEST_RD_START, DS_START};
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    {rd, er} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'h0;
  endtask : apb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wreg
  task automatic msg(input logic [31:0] x, input logic [31:0] y, input logic [31:0] m,
                     input logic [31:0] a);
    wreg(8'h00, x);
    wreg(8'h04, y);
    wreg(8'h08, m);
    wreg(8'h10, a);
  endtask : msg
  // memory side stalls one cycle before taking the write
  task automatic go(input logic [31:0] s, input logic [31:0] c);
    int n;
    clr <= 1'b1;
    wreg(8'h1c, s);
    clr <= 1'b0;
    wreg(8'h18, c);
    for (n = 0; n < 20 && MEM_VALID !== 1'b1 && !seen[4]; n++) @(posedge CLK);
    {mx, my, mm, ma, mr} = {MEM_X, MEM_Y, MEM_MASK, MEM_ARRAY, MEM_READ};
    MEM_READY <= MEM_VALID;
    @(posedge CLK);
    MEM_READY <= 1'b0;
    repeat (3) @(posedge CLK);
    apb(1'b0, 8'h20, 32'h0, st, e);
  endtask : go
  function automatic logic [31:0] em(input logic [31:0] lit, input int x, input int y,
                                     input int w, input int h);
    for (int b = 0; b < 32; b++)
      if (x + b[0] + 2 * b[2] + 4 * b[4] >= w || y + b[1] + 2 * b[3] >= h) lit[b] = 1'b0;
    return lit;
  endfunction : em
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 32'h1);
    wreg(8'h0c, 32'hab00003c);
    msg(32'h38, 32'h4, 32'h5a5af00f, 32'h1);
    go(32'h13c, 32'h103);
    chk(mm, em(32'h5a5af00f, 56, 4, 60, 8));
    chk(seen, 32'h2f);
    chk(SB_TAG, 32'h3c);
    chk(mx, 32'h38);
    chk(my, 32'h4);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk(r, 32'hab00003c);
    BLEND_EN <= 1'b0;
    DEPTH_EN <= 1'b0;
    wreg(8'h14, 32'h0000ffff);
    msg(32'h0, 32'h0, 32'h5a5af00f, 32'h5);
    go(32'h10c, 32'h100);
    chk(mm, 32'h0000ffff);
    chk({ma, seen}, 32'h44);
    msg(32'h38, 32'h4, 32'h0, 32'h2);
    go(32'h10c, 32'h105);
    chk(mm, 32'hffffffff);
    chk(mr, 32'h1);
    SURF_KIND <= one_dim_surface_kind;
    msg(32'h8, 32'h0, 32'hffffffff, 32'h2);
    go(32'h00c, 32'h101);
    chk(mm, em(32'hffffffff, 8, 0, 60, 1));
    chk(my, 32'h0);
    chk(ma, 32'h2);
    SURF_KIND <= linear_buffer_surface_kind;
    go(32'h40c, 32'h101);
    chk(st, 32'h1 << 15);
    wreg(8'h10, 32'h0);
    go(32'h40c, 32'h101);
    chk(st, 32'h0);
    chk(ma, 32'h0);
    SURF_KIND <= structured_buffer_surface_kind;
    go(32'h50c, 32'h103);
    chk(seen, 32'h18);
    SURF_KIND <= two_dim_surface_kind;
    go(32'h10c, 32'h109);
    go(32'h10c, 32'h111);
    chk(st, 32'h0);
    chk(seen, 32'h4);
    for (int i = 0; i < 8; i++) begin
      msg(xs[i], ys[i], 32'hffffffff, 32'h0);
      go(sv[i], cv[i]);
      chk(st, 32'h100 << (i < 7 ? i : 6));
      chk(seen, 32'h0);
    end
    msg(32'h0, 32'h0, 32'hffffffff, 32'h0);
    go(32'h12c, 32'h101);
    chk(st, 32'h2000);
    wrap_up();
  end
  // 18 launches of under 80 cycles each
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
